// [pmc_board.sv]
`timescale 1ns/100ps
// Board logic that feeds the cell terms and the dedicated enable pin.
module pmc_board #(
	parameter int unsigned N = pmc_pkg::NUM_CELLS
) (
	// Terms and pin.
	output logic [N-1:0] term_a,
	output logic [N-1:0] term_b,
	output logic [2:0]   oe_term,
	output logic         oe_pin_n
);
	// Pin parked high so outputs stay off until asked for.
	initial begin
		term_a = '0;
		term_b = '0;
		oe_term = '0;
		oe_pin_n = 1'b1;
	end
	// Called just after a rising edge; the change lands clear of the next sampling edge.
	task automatic drive(input logic [N-1:0] a, b, input logic [2:0] t, input logic p);
		term_a <= a;
		term_b <= b;
		oe_term <= t;
		oe_pin_n <= p;
	endtask : drive
endmodule : pmc_board

// [pmc_cell.sv]
`timescale 1ns/100ps
// One user register cell: JK or D-with-enable, cleared asynchronously by the init term.
module pmc_cell (
	// Clock and resets.
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic init_term,
	// Configuration.
	input  wire logic run,
	input  wire logic d_mode,
	input  wire logic inv_a,
	input  wire logic inv_b,
	input  wire logic out_low,
	// Logic terms: J and K, or D and E.
	input  wire logic term_a,
	input  wire logic term_b,
	// Results.
	output logic      state_q,
	output logic      pin_q
);

	logic a;
	logic b;
	logic state_d;

	// Polarity is applied before the register sees either term.
	assign a = term_a ^ inv_a;
	assign b = term_b ^ inv_b;

	// Next state; a T cell is the JK case with both terms tied, so 1 toggles and 0 holds.
	always_comb begin
		state_d = state_q;
		if (run) begin
			if (d_mode) begin
				if (b) begin
					state_d = a;
				end else begin
					state_d = state_q;
				end
			end else begin
				unique case ({a, b})
					2'b00: state_d = state_q;
					2'b01: state_d = 1'b0;
					2'b10: state_d = 1'b1;
					2'b11: state_d = ~state_q;
				endcase
			end
		end
	end

	// The init term clears without a clock and wins over any enabled edge.
	always_ff @(posedge pclk or negedge presetn or posedge init_term) begin
		if (!presetn) begin
			state_q <= 1'b0;
		end else if (init_term) begin
			state_q <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// The pin copy follows one edge after an init, since an async clear may only load a constant
	// and the idle pin level depends on the programmed polarity.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b0;
		end else if (init_term) begin
			pin_q <= out_low;
		end else begin
			pin_q <= state_d ^ out_low;
		end
	end

endmodule : pmc_cell

// [pmc_macrocells.sv]
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Operation
// - Every cell has its own bit that turns its JK register into a D register with enable.
// - A D cell whose enable is low keeps its value on clock edges whatever its data is.
// - A D cell whose enable is high takes its data input on the clock edge.
// - The data and enable terms of a D cell each pass a programmable inversion first.
// - Normal next-state behaviour applies only while the init term is inactive.
// - One shared init term clears every cell at once without waiting for a clock; the code loads the pin copy with out_low on the next clock edge.
// - The init clears every register whatever its contents, page state or inputs.
// - After init each register keeps its cleared value until an enabled clock edge.
// - Each output enable comes from one of three shared enable terms or the enable pin.
// - Each output has programmable polarity for both the pin and the feedback path; the code applies out_low to the pin copy only.
// - With pin enable chosen, a falling pin edge enables outputs and a rising edge disables.
// - Apart from the asynchronous init clear, every cell updates only on the rising edge of the single clock.
// - In JK mode the cell holds on 00, clears on 01, sets on 10 and toggles on 11.
module pmc_macrocells #(
	parameter int unsigned N_CELLS = pmc_pkg::NUM_CELLS
) (
	// Clock and reset.
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave.
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic [31:0]                     prdata,
	// Array-side terms.
	input  wire logic                       init_term,
	input  wire logic [N_CELLS-1:0]         term_a,
	input  wire logic [N_CELLS-1:0]         term_b,
	input  wire logic [pmc_pkg::NUM_OE_TERM-1:0] oe_term,
	// Dedicated output enable pin, active low.
	input  wire logic                       oe_pin_n,
	// Cell outputs.
	output logic [N_CELLS-1:0]              cell_state,
	output logic [N_CELLS-1:0]              cell_pin,
	output logic [N_CELLS-1:0]              cell_pin_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	localparam int unsigned CNT_W = $clog2(pmc_pkg::CLK_VALID_CYC + 1);

	typedef struct packed {
		pmc_pkg::pmc_cfg_type [N_CELLS-1:0] cfg;
		logic [N_CELLS-1:0]                 oe;
		logic                               pin_en;
		logic                               pin_prev;
		logic [CNT_W-1:0]                   warm;
		logic                               run;
		pmc_pkg::pmc_apb_rsp_type           rsp;
	} pmc_state_type;

	pmc_state_type st_q;
	pmc_state_type st_d;

	pmc_pkg::pmc_apb_req_type req;
	logic [N_CELLS-1:0]       pin_sel;
	logic [N_CELLS-1:0]       state_w;
	logic [N_CELLS-1:0]       pin_w;
	logic                     pin_en_nx;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	////////////////////////////////////////////////////////////////////////////////
	// Cells.
	genvar gi;
	generate
		for (gi = 0; gi < N_CELLS; gi++) begin : g_cell
			pmc_cell u_cell (
				.pclk      (pclk),
				.presetn   (presetn),
				.init_term (init_term),
				.run       (st_q.run),
				.d_mode    (st_q.cfg[gi].d_mode),
				.inv_a     (st_q.cfg[gi].inv_a),
				.inv_b     (st_q.cfg[gi].inv_b),
				.out_low   (st_q.cfg[gi].out_low),
				.term_a    (term_a[gi]),
				.term_b    (term_b[gi]),
				.state_q   (state_w[gi]),
				.pin_q     (pin_w[gi])
			);

			// Each cell picks its own enable source.
			always_comb begin
				unique case (st_q.cfg[gi].oe_sel)
					pmc_pkg::PMC_OE_TERM0: pin_sel[gi] = oe_term[0];
					pmc_pkg::PMC_OE_TERM1: pin_sel[gi] = oe_term[1];
					pmc_pkg::PMC_OE_TERM2: pin_sel[gi] = oe_term[2];
					pmc_pkg::PMC_OE_PIN:   pin_sel[gi] = pin_en_nx;
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin latch, kept apart from the state copy so the enable select reads no loop.
	always_comb begin
		pin_en_nx = st_q.pin_en;
		if (st_q.pin_prev && !oe_pin_n) begin
			pin_en_nx = 1'b1;
		end else if (!st_q.pin_prev && oe_pin_n) begin
			pin_en_nx = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		logic        access;
		logic        mapped;
		logic [31:0] rd;
		int unsigned idx;
		access = 1'b0;
		mapped = 1'b0;
		rd     = 32'h0000_0000;
		idx    = 0;
		st_d   = st_q;

		// Cells are held off until the clock has been valid for the settle time.
		if (!st_q.run) begin
			if (st_q.warm == CNT_W'(pmc_pkg::CLK_VALID_CYC - 1)) begin
				st_d.run = 1'b1;
			end else begin
				st_d.warm = st_q.warm + CNT_W'(1);
			end
		end

		// The pin acts on its edges: falling enables, rising disables.
		st_d.pin_prev = oe_pin_n;
		st_d.pin_en   = pin_en_nx;

		// Output enables are registered so the pins see a clean level.
		st_d.oe = pin_sel;

		// One wait state: the first access cycle decodes, the second answers.
		st_d.rsp.pready  = 1'b0;
		st_d.rsp.pslverr = 1'b0;
		access = req.psel && req.penable && !st_q.rsp.pready;
		if (access) begin
			if (req.paddr[1:0] != 2'b00) begin
				mapped = 1'b0;
			end else if (req.paddr == pmc_pkg::OFS_STATE) begin
				mapped = !req.pwrite;
				rd = 32'(state_w);
			end else if (req.paddr == pmc_pkg::OFS_OE_STAT) begin
				mapped = !req.pwrite;
				rd = 32'(st_q.oe);
			end else if (req.paddr == pmc_pkg::OFS_PIN_STAT) begin
				mapped = !req.pwrite;
				rd = 32'(pin_w);
			end else if (req.paddr == pmc_pkg::OFS_MISC) begin
				mapped = !req.pwrite;
				rd[pmc_pkg::MISC_PIN_EN_BIT] = st_q.pin_en;
				rd[pmc_pkg::MISC_READY_BIT]  = st_q.run;
			end else if (req.paddr >= pmc_pkg::OFS_CFG_BASE) begin
				idx = 32'((req.paddr - pmc_pkg::OFS_CFG_BASE) >> 2);
				if (idx < N_CELLS) begin
					mapped = 1'b1;
					rd = 32'(st_q.cfg[idx]);
					if (req.pwrite) begin
						st_d.cfg[idx] = pmc_pkg::pmc_cfg_type'(req.pwdata[pmc_pkg::CFG_WIDTH-1:0]);
					end
				end
			end
			st_d.rsp.pready  = 1'b1;
			st_d.rsp.pslverr = !mapped;
			st_d.rsp.prdata  = (mapped && !req.pwrite) ? rd : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; presetn only, the init term touches the cells alone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q.cfg      <= {N_CELLS{pmc_pkg::CFG_RESET}};
			st_q.oe       <= '0;
			st_q.pin_en   <= 1'b0;
			st_q.pin_prev <= 1'b1;
			st_q.warm     <= '0;
			st_q.run      <= 1'b0;
			st_q.rsp      <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from registers.
	assign pready      = st_q.rsp.pready;
	assign pslverr     = st_q.rsp.pslverr;
	assign prdata      = st_q.rsp.prdata;
	assign cell_state  = state_w;
	assign cell_pin    = pin_w;
	assign cell_pin_oe = st_q.oe;

endmodule : pmc_macrocells

// [pmc_pkg.sv]
// Shared constants and carriers for the programmable macrocell block.
package pmc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Geometry.
	localparam int unsigned NUM_CELLS   = 24;
	localparam int unsigned NUM_OE_TERM = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB.
	localparam logic [11:0] OFS_STATE    = 12'h000;
	localparam logic [11:0] OFS_OE_STAT  = 12'h004;
	localparam logic [11:0] OFS_PIN_STAT = 12'h008;
	localparam logic [11:0] OFS_MISC     = 12'h00C;
	localparam logic [11:0] OFS_CFG_BASE = 12'h040;

	// Field positions of a cell configuration word.
	localparam int unsigned CFG_D_MODE_BIT  = 0;
	localparam int unsigned CFG_INV_A_BIT   = 1;
	localparam int unsigned CFG_INV_B_BIT   = 2;
	localparam int unsigned CFG_OUT_LOW_BIT = 3;
	localparam int unsigned CFG_OE_SEL_LSB  = 4;
	localparam int unsigned CFG_WIDTH       = 6;

	// Field positions of the miscellaneous status word.
	localparam int unsigned MISC_PIN_EN_BIT = 0;
	localparam int unsigned MISC_READY_BIT  = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned CLK_VALID_NS    = 100;
	localparam int unsigned CLK_VALID_CYC   = (CLK_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {
		PMC_OE_TERM0,
		PMC_OE_TERM1,
		PMC_OE_TERM2,
		PMC_OE_PIN
	} pmc_oe_sel_type;

	typedef struct packed {
		pmc_oe_sel_type oe_sel;
		logic           out_low;
		logic           inv_b;
		logic           inv_a;
		logic           d_mode;
	} pmc_cfg_type;

	localparam pmc_cfg_type CFG_RESET = '{oe_sel: PMC_OE_PIN, out_low: 1'b0, inv_b: 1'b0,
		inv_a: 1'b0, d_mode: 1'b0};

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pmc_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pmc_apb_rsp_type;

endpackage : pmc_pkg

// [pmc_props.sv]
`timescale 1ns/100ps
// Port checker for the macrocell block: bus answers and init behaviour.
module pmc_props #(
	parameter int unsigned N_CELLS = 24
) (
	// Clock and reset.
	input wire logic                              pclk,
	input wire logic                              presetn,
	// APB slave.
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pwrite,
	input wire logic [11:0]                       paddr,
	input wire logic [31:0]                       pwdata,
	input wire logic                              pready,
	input wire logic                              pslverr,
	input wire logic [31:0]                       prdata,
	// Cell side.
	input wire logic                              init_term,
	input wire logic [N_CELLS-1:0]                term_a,
	input wire logic [N_CELLS-1:0]                term_b,
	input wire logic [pmc_pkg::NUM_OE_TERM-1:0]   oe_term,
	input wire logic                              oe_pin_n,
	input wire logic [N_CELLS-1:0]                cell_state,
	input wire logic [N_CELLS-1:0]                cell_pin,
	input wire logic [N_CELLS-1:0]                cell_pin_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	// The bus answers one cycle after a request is taken, for one cycle only.
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	apb_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	apb_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready unasked");
	err_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	wr_data_a: assert property (pready && pwrite |-> prdata == '0) else $error("prdata on write");
	////////////////////////////////////////////////////////////////////////////////
	// Init clears without a clock and nothing moves until it has gone, nor in the settle time after reset.
	init_clear_a: assert property (init_term |-> cell_state == '0)
		else $error("state not cleared by init");
	init_hold_a: assert property (init_term ##1 !init_term |-> cell_state == '0)
		else $error("state moved under init");
	guard_hold_a: assert property ($rose(presetn) |=> cell_state == '0 [*2])
		else $error("state moved in settle time");
	// Main scenarios.
	cover property (init_term ##1 !init_term);
	cover property (pready && pslverr);
	cover property (pready && !pwrite);
endmodule : pmc_props

bind pmc_macrocells pmc_props #(.N_CELLS(N_CELLS)) u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .init_term, .term_a,
	.term_b, .oe_term, .oe_pin_n, .cell_state, .cell_pin, .cell_pin_oe);

// [tb_top.sv]
`timescale 1ns/100ps
// Random self-checking bench for the macrocell block.
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, init_term, pready, pslverr, er, ih, oe_pin_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] term_a, term_b, cell_state, cell_pin, cell_pin_oe, es, eo, ol, a, b;
	logic [2:0]  oe_term;
	pmc_pkg::pmc_cfg_type cfg [24];
	int          seed = 59, err_total = 0, num_checks = 0, cyc = 0;

	pmc_macrocells u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .init_term, .term_a, .term_b, .oe_term, .oe_pin_n, .cell_state,
		.cell_pin, .cell_pin_oe);
	pmc_board u_brd (.term_a, .term_b, .oe_term, .oe_pin_n);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and a hang limit well above the expected run.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			final_report();
		end
	end

	task final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// One APB transfer; an idle edge first keeps drives one per time step.
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait for the answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Next state of one cell after its term inversions.
	function automatic logic nxt(pmc_pkg::pmc_cfg_type c, logic q, logic ta, logic tb);
		logic x, y;
		x = ta ^ c.inv_a;
		y = tb ^ c.inv_b;
		if (c.d_mode) return y ? x : q;
		case ({x, y})
			2'b00: return q;
			2'b01: return 1'b0;
			2'b10: return 1'b1;
			default: return ~q;
		endcase
	endfunction : nxt

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: refusals, configuration, then random traffic with init bursts.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		init_term = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		u_brd.drive('1, '0, 3'h0, 1'b1);
		// Every cell is asked to set; the settle guard must hold them for two edges.
		repeat (2) begin
			@(posedge pclk);
			#1;
			chk("settle", 32'h0, 32'(cell_state));
		end
		@(posedge pclk);
		#1;
		chk("first edge", 32'h00FF_FFFF, 32'(cell_state));
		@(posedge pclk);
		init_term <= 1'b1;
		#1;
		chk("init clear", 32'h0, 32'(cell_state));
		$display("test reset done");
		apb(1'b0, 12'h040, '0);
		chk("cfg reset", 32'h30, rd);
		apb(1'b0, 12'h010, '0);
		chk("unmapped err", 32'(1), 32'(er));
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		chk("ro err", 32'(1), 32'(er));
		apb(1'b0, 12'h00C, '0);
		chk("misc", 32'h2, rd);
		$display("test bus done");
		for (int i = 0; i < 24; i++) begin
			cfg[i] = pmc_pkg::pmc_cfg_type'(6'($random(seed)));
			if (i == 0) cfg[i] = pmc_pkg::pmc_cfg_type'(6'h00);
			ol[i] = cfg[i].out_low;
			apb(1'b1, 12'h040 + 12'(4 * i), 32'(cfg[i]));
			apb(1'b0, 12'h040 + 12'(4 * i), '0);
			chk("cfg", 32'(cfg[i]), rd);
		end
		$display("test config done");
		es = '0;
		repeat (300) begin
			@(posedge pclk);
			ih = init_term;
			for (int i = 0; i < 24; i++) begin
				if (ih !== 1'b1) es[i] = nxt(cfg[i], es[i], term_a[i], term_b[i]);
				eo[i] = (cfg[i].oe_sel == pmc_pkg::PMC_OE_PIN) ? !oe_pin_n
					: oe_term[cfg[i].oe_sel];
			end
			a = 24'($random(seed));
			b = 24'($random(seed));
			b[0] = a[0];
			u_brd.drive(a, b, 3'($random(seed)), 1'($random(seed)));
			init_term <= (($random(seed) & 15) == 0);
			#1;
			if (init_term) es = '0;
			chk("state", 32'(es), 32'(cell_state));
			if (!(init_term && !ih)) chk("pin", 32'(es ^ ol), 32'(cell_pin));
			chk("oe", 32'(eo), 32'(cell_pin_oe));
		end
		$display("test random done");
		final_report();
	end
endmodule : tb_top
